//--- shared/phd_map.svh
// constants for the peripheral hub dma controller
// assumes one clock; included by bare name
`ifndef PHD_MAP_SVH
`define PHD_MAP_SVH
`define PHD_NCH        24
`define PHD_NTD        128
`define PHD_NLV        8
`define PHD_TDWORDS    512
// descriptor word select
`define PHD_W_SRC      2'h0
`define PHD_W_DST      2'h1
`define PHD_W_CTL      2'h2
`define PHD_W_NXT      2'h3
// control word fields
`define PHD_LEN_HI     15
`define PHD_LEN_LO     0
`define PHD_UNB        16
`define PHD_SZ_HI      18
`define PHD_SZ_LO      17
`define PHD_SINC       19
`define PHD_DINC       20
`define PHD_IRQ0       21
`define PHD_IRQ1       22
// next word: bit 7 set marks end of chain
`define PHD_NXT_HI     7
`define PHD_NXT_END    7
`define PHD_TD_END     8'hFF
// spoke field of an address, spoke 0 holds memory
`define PHD_SP_HI      31
`define PHD_SP_LO      29
// descriptor window
`define PHD_WIN_HI     31
`define PHD_WIN_LO     11
`define PHD_WIN_BASE   21'h080000
`define PHD_IX_HI      10
`define PHD_IX_LO      2
// cycles a blocked dma waits before the cpu is held off
`define PHD_STARVE_MAX 4'h8
`define PHD_FAIR_LV0   3'h2
`define PHD_LV_MAX     3'h7
`define PHD_FAIR_BITS  5
`endif

//--- shared/phd_pkg.sv
// types of the peripheral hub dma controller
// assumes phd_map.svh for widths
`include "phd_map.svh"
package phd_pkg;
    // static per-channel setup
    typedef struct packed {
        logic       en;
        logic [2:0] prio;
        logic       rr_dis;
        logic       chain_en;
        logic [4:0] chain_src;
        logic [6:0] first_td;
        logic [6:0] burst;
    } phd_cfg_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_XFER = 3'b010,
        S_FIN  = 3'b100
    } phd_state_t;
endpackage

//--- rtl/phd_hub.sv
// dma engine of the peripheral hub
// assumes single-cycle spokes answering with rdy; inputs synchronous
//
// Overview of operation
// - 24 channels, 128 shared descriptors
// - eight priority levels, lower number wins
// - start by signal, cpu or chained channel
// - two interrupts per transfer
// - transactions can be stalled or cancelled
// - length unbounded or 1 to 64k bytes
// - bursts of 1 to 127 bytes
// - chaining, nesting, live descriptor updates
// - cpu first, dma never starved
// - preempt only after current burst
// - fairness shares for levels 2 to 7
// - levels 0 and 1 outside fairness
// - round robin among equal priority
// - per-channel round robin opt-out wins ties
// - fairness off: pure priority
// - eight spokes, memory on spoke 0
// - cpu and dma on different spokes together
// - source and sink bursts concurrent on different spokes
// - 8, 16, 24 or 32 bit accesses
// - self link gives auto repeat
// - rings of descriptors loop around
// - descriptors writable as dma destination
`include "phd_map.svh"
module phd_hub (
    input  wire logic                         CLOCK_I,
    input  wire logic                         RST_I,
    input  wire logic                         CE_I,
    input  wire phd_pkg::phd_cfg_t [`PHD_NCH-1:0] CH_CFG_I,
    input  wire logic [`PHD_NCH-1:0]          HW_TRIG_I,
    input  wire logic [`PHD_NCH-1:0]          CPU_TRIG_I,
    input  wire logic [`PHD_NCH-1:0]          STALL_I,
    input  wire logic [`PHD_NCH-1:0]          CANCEL_I,
    input  wire logic                         FAIR_EN_I,
    input  wire logic                         TD_WE_I,
    input  wire logic [8:0]                   TD_ADDR_I,
    input  wire logic [31:0]                  TD_WDATA_I,
    output logic [31:0]                       TD_RDATA_O,
    input  wire logic                         CPU_REQ_I,
    input  wire logic [2:0]                   CPU_SPOKE_I,
    output logic                              CPU_GNT_O,
    output logic                              SRC_REQ_O,
    output logic [31:0]                       SRC_ADDR_O,
    output logic [1:0]                        SRC_SIZE_O,
    input  wire logic                         SRC_RDY_I,
    input  wire logic [31:0]                  SRC_DATA_I,
    output logic                              DST_REQ_O,
    output logic [31:0]                       DST_ADDR_O,
    output logic [1:0]                        DST_SIZE_O,
    output logic [31:0]                       DST_DATA_O,
    input  wire logic                         DST_RDY_I,
    output logic [`PHD_NCH-1:0]               CH_ACT_O,
    output logic [`PHD_NCH-1:0]               CH_DONE_O,
    output logic [`PHD_NCH-1:0]               IRQ0_O,
    output logic [`PHD_NCH-1:0]               IRQ1_O,
    output logic                              BUSY_O
);
    import phd_pkg::*;

    // descriptor pool and per-channel progress
    logic [31:0]         td_mem [0:`PHD_TDWORDS-1];
    logic [`PHD_NCH-1:0] act_q;
    logic [6:0]          td_q  [`PHD_NCH];
    logic [16:0]         off_q [`PHD_NCH];
    logic [`PHD_NCH-1:0] done_q;
    logic [`PHD_NCH-1:0] irq0_q;
    logic [`PHD_NCH-1:0] irq1_q;

    // engine registers
    phd_state_t  st_q;
    logic [4:0]  ch_q;
    logic [31:0] sa_q;
    logic [31:0] da_q;
    logic [31:0] ctl_q;
    logic [7:0]  nxt_q;
    logic [6:0]  rdl_q;
    logic [6:0]  wrl_q;
    logic [6:0]  bn_q;
    logic [31:0] hold_q;
    logic [1:0]  hn_q;
    logic        hv_q;
    logic        ab_q;
    logic [6:0]  slot_q;
    logic [4:0]  rr_q [`PHD_NLV];
    logic [3:0]  starve_q;

    // arbitration wires
    logic [`PHD_NCH-1:0] pend;
    logic [`PHD_NLV-1:0] lv_any;
    logic [2:0]          best;
    logic [2:0]          fl;
    logic [2:0]          lv;
    logic                use_fair;
    logic [4:0]          pick;
    logic                pick_v;

    // eligible channels; stalled ones skipped
    always_comb begin
        lv_any = '0;
        for (int i = 0; i < `PHD_NCH; i++) begin
            pend[i] = act_q[i] & ~STALL_I[i] & CH_CFG_I[i].en & ~CANCEL_I[i];
            if (pend[i]) begin
                lv_any[CH_CFG_I[i].prio] = 1'b1;
            end
        end
    end

    // highest pending level
    always_comb begin
        best = `PHD_LV_MAX;
        for (int l = `PHD_NLV - 1; l >= 0; l--) begin
            if (lv_any[l]) begin
                best = 3'(l);
            end
        end
    end

    // favoured level: trailing ones of the slot count give 50/25/12.5..%
    always_comb begin
        logic go;
        go = 1'b1;
        fl = `PHD_FAIR_LV0;
        for (int k = 0; k < `PHD_FAIR_BITS; k++) begin
            if (go && slot_q[k]) begin
                fl = fl + 3'h1;
            end else begin
                go = 1'b0;
            end
        end
    end

    // levels 0 and 1 take the bus outright; fairness off is pure priority
    assign use_fair = FAIR_EN_I & ~lv_any[0] & ~lv_any[1] & lv_any[fl];
    assign lv       = use_fair ? fl : best;

    // opt-out channels first, else rotate from last grant
    always_comb begin
        logic [`PHD_NCH-1:0] cand;
        logic                fix;
        int                  idx;
        cand = '0;
        fix  = 1'b0;
        pick = '0;
        idx  = 0;
        for (int i = 0; i < `PHD_NCH; i++) begin
            cand[i] = pend[i] & (CH_CFG_I[i].prio == lv);
        end
        pick_v = |cand;
        for (int i = `PHD_NCH - 1; i >= 0; i--) begin
            if (cand[i] && CH_CFG_I[i].rr_dis) begin
                pick = 5'(i);
                fix  = 1'b1;
            end
        end
        if (!fix) begin
            for (int k = `PHD_NCH - 1; k >= 0; k--) begin
                idx = int'(rr_q[lv]) + 1 + k;
                if (idx >= `PHD_NCH) begin
                    idx = idx - `PHD_NCH;
                end
                if (cand[idx]) begin
                    pick = 5'(idx);
                end
            end
        end
    end

    // descriptor fetch for the chosen channel
    logic [6:0]  ptd;
    logic [31:0] w_src;
    logic [31:0] w_dst;
    logic [31:0] w_ctl;
    logic [31:0] w_nxt;
    logic [16:0] p_off;
    logic [16:0] p_rem;
    logic [6:0]  p_bl;
    logic [6:0]  p_bn;
    assign ptd   = td_q[pick];
    assign w_src = td_mem[{ptd, `PHD_W_SRC}];
    assign w_dst = td_mem[{ptd, `PHD_W_DST}];
    assign w_ctl = td_mem[{ptd, `PHD_W_CTL}];
    assign w_nxt = td_mem[{ptd, `PHD_W_NXT}];
    assign p_off = off_q[pick];
    // stored length is count minus one, so 16 bits reach 64k
    assign p_rem = {1'b0, w_ctl[`PHD_LEN_HI:`PHD_LEN_LO]} + 17'h00001 - p_off;
    assign p_bl  = (CH_CFG_I[pick].burst == 7'h00) ? 7'h01 : CH_CFG_I[pick].burst;
    assign p_bn  = (w_ctl[`PHD_UNB] || p_rem > {10'h000, p_bl}) ? p_bl : p_rem[6:0];

    // spoke decode and cpu contention
    logic [2:0] s_sp;
    logic [2:0] d_sp;
    logic       dst_td;
    logic       starve;
    logic       blk_s;
    logic       blk_d;
    assign s_sp   = sa_q[`PHD_SP_HI:`PHD_SP_LO];
    assign d_sp   = da_q[`PHD_SP_HI:`PHD_SP_LO];
    assign dst_td = da_q[`PHD_WIN_HI:`PHD_WIN_LO] == `PHD_WIN_BASE;
    assign starve = starve_q == `PHD_STARVE_MAX;
    // cpu wins a shared spoke until the dma has waited too long
    assign blk_s  = CPU_REQ_I & (CPU_SPOKE_I == s_sp) & ~starve;
    assign blk_d  = CPU_REQ_I & (CPU_SPOKE_I == d_sp) & ~starve;

    // beat sizing, read/write overlap
    logic [1:0] sz;
    logic [1:0] nb;
    logic       xfer;
    logic       wr_want;
    logic       wr_fire;
    logic       rd_ok;
    logic       rd_want;
    logic       rd_fire;
    logic       wr_last;
    assign xfer    = (st_q == S_XFER) & ~ab_q;
    assign sz      = ctl_q[`PHD_SZ_HI:`PHD_SZ_LO];
    assign nb      = ({5'h00, sz} >= rdl_q) ? 2'(rdl_q - 7'h01) : sz;
    assign wr_want = xfer & hv_q;
    // descriptor window writes stay internal and never wait
    assign wr_fire = wr_want & (dst_td | (DST_RDY_I & ~blk_d));
    // next read may overlap a write only on another spoke
    assign rd_ok   = ~hv_q | (wr_fire & (s_sp != d_sp));
    assign rd_want = xfer & rd_ok & (rdl_q != 7'h00);
    assign rd_fire = rd_want & SRC_RDY_I & ~blk_s;
    assign wr_last = wr_fire & (wrl_q == {5'h00, hn_q} + 7'h01);

    // bus requests; cpu shares the hub when spokes differ
    assign SRC_REQ_O  = rd_want & ~blk_s;
    assign DST_REQ_O  = wr_want & ~dst_td & ~blk_d;
    assign SRC_SIZE_O = nb;
    assign SRC_ADDR_O = sa_q;
    assign DST_ADDR_O = da_q;
    assign DST_DATA_O = hold_q;
    assign DST_SIZE_O = hn_q;
    assign CPU_GNT_O  = CPU_REQ_I & ~(SRC_REQ_O & (CPU_SPOKE_I == s_sp))
                                  & ~(DST_REQ_O & (CPU_SPOKE_I == d_sp));
    assign CH_ACT_O   = act_q;
    assign CH_DONE_O  = done_q;
    assign IRQ0_O     = irq0_q;
    assign IRQ1_O     = irq1_q;
    assign BUSY_O     = st_q != S_IDLE;

    // end of burst bookkeeping
    logic [16:0] f_off;
    logic        f_tdend;
    logic        f_chend;
    assign f_off   = off_q[ch_q] + {10'h000, bn_q};
    assign f_tdend = ~ctl_q[`PHD_UNB]
                   & (f_off == {1'b0, ctl_q[`PHD_LEN_HI:`PHD_LEN_LO]} + 17'h00001);
    assign f_chend = nxt_q[`PHD_NXT_END];

    // cycles the dma is held off
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            starve_q <= 4'h0;
        end else if (CE_I) begin
            if (rd_fire || (wr_fire && !dst_td) || !xfer) begin
                starve_q <= 4'h0;
            end else if (!starve && ((rd_want && blk_s) || (wr_want && !dst_td && blk_d))) begin
                starve_q <= starve_q + 4'h1;
            end
        end
    end

    // engine: arbitrate only between bursts, so a running burst ends first
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            st_q   <= S_IDLE;
            ch_q   <= 5'h00;
            sa_q   <= 32'h00000000;
            da_q   <= 32'h00000000;
            ctl_q  <= 32'h00000000;
            nxt_q  <= `PHD_TD_END;
            rdl_q  <= 7'h00;
            wrl_q  <= 7'h00;
            bn_q   <= 7'h00;
            hold_q <= 32'h00000000;
            hn_q   <= 2'h0;
            hv_q   <= 1'b0;
            ab_q   <= 1'b0;
            slot_q <= 7'h00;
            for (int l = 0; l < `PHD_NLV; l++) begin
                rr_q[l] <= 5'h00;
            end
        end else if (CE_I) begin
            unique case (st_q)
                S_IDLE: begin
                    if (pick_v) begin
                        st_q     <= S_XFER;
                        ch_q     <= pick;
                        sa_q     <= w_src + (w_ctl[`PHD_SINC] ? {15'h0000, p_off} : 32'h0);
                        da_q     <= w_dst + (w_ctl[`PHD_DINC] ? {15'h0000, p_off} : 32'h0);
                        ctl_q    <= w_ctl;
                        nxt_q    <= w_nxt[`PHD_NXT_HI:0];
                        rdl_q    <= p_bn;
                        wrl_q    <= p_bn;
                        bn_q     <= p_bn;
                        hv_q     <= 1'b0;
                        ab_q     <= 1'b0;
                        slot_q   <= slot_q + 7'h01;
                        rr_q[lv] <= pick;
                    end
                end
                S_XFER: begin
                    if (CANCEL_I[ch_q]) begin
                        ab_q <= 1'b1;
                        hv_q <= 1'b0;
                        st_q <= S_FIN;
                    end else begin
                        if (rd_fire) begin
                            hold_q <= SRC_DATA_I;
                            hn_q   <= nb;
                            rdl_q  <= rdl_q - {5'h00, nb} - 7'h01;
                            if (ctl_q[`PHD_SINC]) begin
                                sa_q <= sa_q + {30'h0, nb} + 32'h1;
                            end
                        end
                        if (wr_fire) begin
                            wrl_q <= wrl_q - {5'h00, hn_q} - 7'h01;
                            if (ctl_q[`PHD_DINC]) begin
                                da_q <= da_q + {30'h0, hn_q} + 32'h1;
                            end
                        end
                        hv_q <= rd_fire | (hv_q & ~wr_fire);
                        if (wr_last) begin
                            st_q <= S_FIN;
                        end
                    end
                end
                S_FIN: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    // channel progress
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            act_q  <= '0;
            done_q <= '0;
            irq0_q <= '0;
            irq1_q <= '0;
            for (int i = 0; i < `PHD_NCH; i++) begin
                td_q[i]  <= 7'h00;
                off_q[i] <= 17'h00000;
            end
        end else if (CE_I) begin
            done_q <= '0;
            irq0_q <= '0;
            irq1_q <= '0;
            for (int i = 0; i < `PHD_NCH; i++) begin
                logic cs;
                logic st;
                cs = CH_CFG_I[i].chain_en && (CH_CFG_I[i].chain_src < 5'(`PHD_NCH))
                     && done_q[CH_CFG_I[i].chain_src];
                st = (HW_TRIG_I[i] || CPU_TRIG_I[i] || cs) && CH_CFG_I[i].en;
                if (st_q == S_FIN && ch_q == 5'(i) && !ab_q) begin
                    if (f_tdend) begin
                        irq0_q[i] <= ctl_q[`PHD_IRQ0];
                        irq1_q[i] <= ctl_q[`PHD_IRQ1];
                        off_q[i]  <= 17'h00000;
                        if (f_chend) begin
                            act_q[i]  <= 1'b0;
                            done_q[i] <= 1'b1;
                        end else begin
                            // a self link repeats, a back link closes a ring
                            td_q[i] <= nxt_q[6:0];
                        end
                    end else begin
                        off_q[i] <= f_off;
                    end
                end
                if (CANCEL_I[i]) begin
                    act_q[i] <= 1'b0;
                end
                // a start on an idle channel wins over a same-cycle cancel
                if (st && !act_q[i]) begin
                    act_q[i] <= 1'b1;
                    td_q[i]  <= CH_CFG_I[i].first_td;
                    off_q[i] <= 17'h00000;
                end
            end
        end
    end

    // descriptor pool: dma write beats cpu write
    always_ff @(posedge CLOCK_I) begin
        if (CE_I) begin
            if (wr_fire && dst_td) begin
                td_mem[da_q[`PHD_IX_HI:`PHD_IX_LO]] <= hold_q;
            end else if (TD_WE_I) begin
                td_mem[TD_ADDR_I] <= TD_WDATA_I;
            end
        end
    end

    // cpu readback, one cycle late
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            TD_RDATA_O <= 32'h00000000;
        end else if (CE_I) begin
            TD_RDATA_O <= td_mem[TD_ADDR_I];
        end
    end
endmodule // phd_hub

//--- verification/phd_hub_monitor.sv
// port checker of the hub
// assumes one clock, sync reset; bound below
`include "phd_map.svh"
module phd_hub_monitor (
    input wire logic                CLOCK_I,
    input wire logic                RST_I,
    input wire logic                CE_I,
    input wire logic [`PHD_NCH-1:0] CANCEL_I,
    input wire logic                CPU_REQ_I,
    input wire logic [2:0]          CPU_SPOKE_I,
    input wire logic                CPU_GNT_O,
    input wire logic                SRC_REQ_O,
    input wire logic [31:0]         SRC_ADDR_O,
    input wire logic                SRC_RDY_I,
    input wire logic                DST_REQ_O,
    input wire logic [31:0]         DST_ADDR_O,
    input wire logic [31:0]         DST_DATA_O,
    input wire logic                DST_RDY_I,
    input wire logic [`PHD_NCH-1:0] CH_ACT_O,
    input wire logic [`PHD_NCH-1:0] CH_DONE_O,
    input wire logic [`PHD_NCH-1:0] IRQ0_O,
    input wire logic [`PHD_NCH-1:0] IRQ1_O,
    input wire logic                BUSY_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    logic [3:0] starve_q;
    // busy cycles behind a granted cpu
    always_ff @(posedge CLOCK_I) begin
        if (RST_I || !(CPU_REQ_I && CPU_GNT_O && BUSY_O) || SRC_REQ_O || DST_REQ_O) begin
            starve_q <= 4'h0;
        end else if (starve_q != 4'hF) begin
            starve_q <= starve_q + 4'h1;
        end
    end
    // cpu may take the spoke from a waiting beat
    AST_SRC_HOLD: assert property (SRC_REQ_O && !SRC_RDY_I && CE_I && !CPU_REQ_I && CANCEL_I == '0
        ##1 !CPU_REQ_I |-> SRC_REQ_O && $stable(SRC_ADDR_O)) else $error("read moved early");
    AST_DST_HOLD: assert property (DST_REQ_O && !DST_RDY_I && CE_I && !CPU_REQ_I && CANCEL_I == '0
        ##1 !CPU_REQ_I |-> DST_REQ_O && $stable({DST_ADDR_O, DST_DATA_O}))
        else $error("write moved early");
    AST_CPU_SPOKE: assert property (CPU_REQ_I && CPU_GNT_O |->
        !(SRC_REQ_O && SRC_ADDR_O[31:29] == CPU_SPOKE_I)
        && !(DST_REQ_O && DST_ADDR_O[31:29] == CPU_SPOKE_I)) else $error("spoke shared");
    AST_NO_STARVE: assert property (starve_q < 4'hC) else $error("dma starved by cpu");
    AST_SPOKES_APART: assert property (SRC_REQ_O && DST_REQ_O |->
        SRC_ADDR_O[31:29] != DST_ADDR_O[31:29]) else $error("overlap on one spoke");
    AST_DONE_DROPS_ACT: assert property (CH_DONE_O != '0 |-> (CH_DONE_O & CH_ACT_O) == '0)
        else $error("active at chain end");
    AST_DONE_PULSE: assert property (CE_I && CH_DONE_O != '0 |=>
        (CH_DONE_O & $past(CH_DONE_O)) == '0) else $error("done too long");
    AST_IRQ_PULSE: assert property (CE_I && (IRQ0_O | IRQ1_O) != '0 |=>
        ((IRQ0_O & $past(IRQ0_O)) | (IRQ1_O & $past(IRQ1_O))) == '0)
        else $error("irq too long");
endmodule // phd_hub_monitor

bind phd_hub phd_hub_monitor u_phd_hub_monitor (.*);

//--- verification/phd_spoke_model.sv
// spoke stand-in: answers reads and writes after a delay
// assumes requests hold until ready
module phd_spoke_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [2:0]  wait_i,
    input  wire logic        src_req_i,
    input  wire logic [31:0] src_addr_i,
    output logic             src_rdy_o,
    output logic [31:0]      src_data_o,
    input  wire logic        dst_req_i,
    output logic             dst_rdy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0]  src_cnt_q;
    logic [2:0]  dst_cnt_q;
    logic [31:0] pat;
    // data = address ^ mask; inverted when not ready
    assign pat = src_addr_i ^ 32'h0000_5A00;
    assign src_rdy_o = src_req_i && (src_cnt_q >= wait_i);
    assign dst_rdy_o = dst_req_i && (dst_cnt_q >= wait_i);
    assign src_data_o = src_rdy_o ? pat : ~pat;
    // counters restart per beat
    always_ff @(posedge clk_i) begin
        src_cnt_q <= (rst_i || !src_req_i || src_rdy_o) ? 3'h0 : src_cnt_q + 3'h1;
        dst_cnt_q <= (rst_i || !dst_req_i || dst_rdy_o) ? 3'h0 : dst_cnt_q + 3'h1;
    end
endmodule // phd_spoke_model

//--- verification/phd_hub_tb.sv
// self-checking bench for the hub
// assumes the spoke model and bound checker
`include "phd_map.svh"
module phd_hub_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import phd_pkg::*;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    logic                td_we = 1'b0;
    logic                cpu_req = 1'b0;
    logic [2:0]          spoke_wait = 3'h0;
    logic [8:0]          td_addr = 9'h000;
    logic [31:0]         td_wdata = 32'h0;
    logic [`PHD_NCH-1:0] hw_trig = '0, cpu_trig = '0, cancel = '0, stall = '0;
    logic [`PHD_NCH-1:0] done_seen = '0, irq0_seen = '0, irq1_seen = '0;
    logic [`PHD_NCH-1:0] ch_act, ch_done, irq0, irq1;
    phd_cfg_t [`PHD_NCH-1:0] cfg = '0;
    logic [31:0]         td_rdata, src_addr, src_data, dst_addr, dst_data;
    logic                cpu_gnt, src_req, src_rdy, dst_req, dst_rdy, busy;
    logic [1:0]          dst_size;
    logic [31:0]         wa[$], wd[$];
    logic [1:0]          ws[$];
    int                  failures = 0, compares = 0;

    always #20 clk = ~clk;

    phd_hub u_phd_hub (.CLOCK_I(clk), .RST_I(rst), .CE_I(1'b1), .CH_CFG_I(cfg),
        .HW_TRIG_I(hw_trig), .CPU_TRIG_I(cpu_trig), .STALL_I(stall), .CANCEL_I(cancel),
        .FAIR_EN_I(1'b0), .TD_WE_I(td_we), .TD_ADDR_I(td_addr), .TD_WDATA_I(td_wdata),
        .TD_RDATA_O(td_rdata), .CPU_REQ_I(cpu_req), .CPU_SPOKE_I(3'h0), .CPU_GNT_O(cpu_gnt),
        .SRC_REQ_O(src_req), .SRC_ADDR_O(src_addr), .SRC_SIZE_O(), .SRC_RDY_I(src_rdy),
        .SRC_DATA_I(src_data), .DST_REQ_O(dst_req), .DST_ADDR_O(dst_addr), .DST_SIZE_O(dst_size),
        .DST_DATA_O(dst_data), .DST_RDY_I(dst_rdy), .CH_ACT_O(ch_act), .CH_DONE_O(ch_done),
        .IRQ0_O(irq0), .IRQ1_O(irq1), .BUSY_O(busy));
    phd_spoke_model u_phd_spoke_model (.clk_i(clk), .rst_i(rst), .wait_i(spoke_wait),
        .src_req_i(src_req), .src_addr_i(src_addr), .src_rdy_o(src_rdy), .src_data_o(src_data),
        .dst_req_i(dst_req), .dst_rdy_o(dst_rdy));

    // beats and pulses gathered at negedge
    always @(negedge clk) begin
        if (!rst && dst_req && dst_rdy) begin
            wa.push_back(dst_addr);
            wd.push_back(dst_data);
            ws.push_back(dst_size);
        end
        done_seen = done_seen | ch_done;
        irq0_seen = irq0_seen | irq0;
        irq1_seen = irq1_seen | irq1;
    end

    task automatic results();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            failures++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    // control word, both increments on
    function automatic logic [31:0] ctl(input int len, input logic [1:0] sz, input logic [1:0] irq);
        return {9'h000, irq, 2'b11, sz, 1'b0, 16'(len - 1)};
    endfunction

    task automatic wr_td(input int td, input logic [31:0] s, d, c, input logic [7:0] n);
        logic [31:0] w [4];
        w = '{s, d, c, {24'h000000, n}};
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            td_we = 1'b1;
            td_addr = 9'(td * 4 + k);
            td_wdata = w[k];
        end
        @(negedge clk);
        td_we = 1'b0;
    endtask

    task automatic setch(input int ch, input logic [2:0] p, input logic [6:0] td,
                         input logic rd, ce, input logic [4:0] cs);
        @(negedge clk);
        cfg[ch] = '{en: 1'b1, prio: p, rr_dis: rd, chain_en: ce, chain_src: cs,
                    first_td: td, burst: 7'h04};
    endtask

    task automatic kick(input logic [`PHD_NCH-1:0] m);
        @(negedge clk);
        cpu_trig = m;
        @(negedge clk);
        cpu_trig = '0;
    endtask

    // bounded wait; timeout fails
    task automatic wait_mask(input logic [`PHD_NCH-1:0] m);
        int n;
        n = 0;
        while ((done_seen & m) !== m && n < 400) begin
            @(negedge clk);
            n++;
        end
        if ((done_seen & m) !== m) begin
            failures++;
            $display("BAD %0t completion timed out", $time);
            results();
        end
    endtask

    // 4 bytes, 2-byte beats, cpu on sink spoke
    task automatic s_simple();
        int b;
        b = wa.size();
        wr_td(0, 32'h2000_0010, 32'h0000_0100, ctl(4, 2'h1, 2'b01), 8'hFF);
        setch(0, 3'h4, 7'h00, 1'b0, 1'b0, 5'h00);
        cpu_req = 1'b1;
        kick(24'h000001);
        chk(ch_act[0] === 1'b1 && cpu_gnt === 1'b1, "start or cpu grant");
        wait_mask(24'h000001);
        cpu_req = 1'b0;
        chk(wa.size() === b + 2, "beat count");
        for (int k = 0; k < 2; k++) begin
            chk(wa[b+k] === 32'h100 + 32'(2 * k) && ws[b+k] === 2'h1, "beat address");
            chk(wd[b+k][15:0] === 16'h5A10 + 16'(2 * k), "beat data");
        end
        chk(irq0_seen[0] === 1'b1 && irq1_seen[0] === 1'b0, "interrupt choice");
    endtask

    // signal start, chained self link, slow spokes, cancel
    task automatic s_ring();
        int b;
        wr_td(1, 32'h2000_0020, 32'h0000_0200, ctl(1, 2'h0, 2'b00), 8'hFF);
        wr_td(2, 32'h2000_0030, 32'h0000_0300, ctl(1, 2'h0, 2'b00), 8'h02);
        setch(1, 3'h2, 7'h01, 1'b0, 1'b0, 5'h00);
        setch(2, 3'h2, 7'h02, 1'b0, 1'b1, 5'h01);
        spoke_wait = 3'h3;
        hw_trig = 24'h000002;
        @(negedge clk);
        hw_trig = '0;
        wait_mask(24'h000002);
        b = wa.size();
        repeat (60) @(negedge clk);
        chk(wa.size() >= b + 3 && ch_act[2] === 1'b1, "no repeat");
        chk(wa[wa.size()-1] === 32'h0000_0300, "repeat address");
        cancel = 24'h000004;
        @(negedge clk);
        cancel = '0;
        b = wa.size();
        repeat (40) @(negedge clk);
        chk(ch_act[2] === 1'b0 && wa.size() <= b + 1, "cancel ignored");
        spoke_wait = 3'h0;
    endtask

    // first descriptor rewrites the second's sink
    task automatic s_nested();
        int b;
        b = wa.size();
        wr_td(3, 32'h6000_0000, 32'h4000_0054, ctl(4, 2'h3, 2'b10), 8'h05);
        wr_td(5, 32'h2000_0040, 32'h0000_0000, ctl(4, 2'h3, 2'b00), 8'hFF);
        setch(6, 3'h3, 7'h03, 1'b0, 1'b0, 5'h00);
        kick(24'h000040);
        wait_mask(24'h000040);
        chk(wa.size() === b + 1 && wa[b] === 32'h6000_5A00, "rewritten sink");
        chk(wd[b] === 32'h2000_5A40, "chained data");
        chk(irq1_seen[6] === 1'b1 && irq0_seen[6] === 1'b0, "second interrupt");
        @(negedge clk);
        td_addr = 9'h015;
        @(negedge clk);
        chk(td_rdata === 32'h6000_5A00, "descriptor readback");
    endtask

    task automatic race(input logic [`PHD_NCH-1:0] m, input int exp);
        int b;
        b = wa.size();
        kick(m);
        done_seen = '0;
        wait_mask(m & ~stall);
        chk(wa[b][7:4] === 4'(exp), "wrong winner");
    endtask

    // channels 3, 4 at level 5, channel 5 at 0
    task automatic s_arb();
        for (int c = 3; c < 6; c++) begin
            wr_td(c + 8, 32'h2000_0000 | (32'(c) << 4), 32'(c) << 4, ctl(1, 2'h0, 2'b00), 8'hFF);
            setch(c, (c == 5) ? 3'h0 : 3'h5, 7'(c + 8), 1'b0, 1'b0, 5'h00);
        end
        race(24'h000038, 5);
        stall = 24'h000020;
        race(24'h000030, 4);
        stall = '0;
        wait_mask(24'h000020);
        race(24'h000008, 3);
        race(24'h000018, 4);
        race(24'h000010, 4);
        race(24'h000018, 3);
        setch(4, 3'h5, 7'h0C, 1'b1, 1'b0, 5'h00);
        race(24'h000010, 4);
        race(24'h000018, 4);
    endtask

    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        s_simple();
        s_ring();
        s_nested();
        s_arb();
        results();
    end
endmodule // phd_hub_tb
